// >>> common/ffc_pkg.sv
package ffc_pkg;
	localparam int CELL_COUNT = 8;
	localparam int RES_W = 26;
	localparam int COEF_W = 9;
	localparam int SEL_W = 3;
	localparam int DCM_W = 2;
	localparam int MAX_DECIM = 3;
	localparam int BUF_DROP = 8;
	localparam int RES_HIGH_LSB = 16;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;

	localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
	localparam logic [APB_AW-1:0] SAMPLE_OFS = 12'h004;
	localparam logic [APB_AW-1:0] RESULT_OFS = 12'h008;

	localparam int CTRL_DCM_LSB = 0;
	localparam int CTRL_SEL_LSB = 2;
	localparam int CTRL_SHIFT_ADD_SELECT_BIT = 5;
	localparam int CTRL_REGCLR_N_BIT = 6;
	localparam int CTRL_ACCCLR_N_BIT = 7;
	localparam int CTRL_HIGH_EN_N_BIT = 8;
	localparam int CTRL_LOW_EN_N_BIT = 9;
	localparam int SAMPLE_COEF_LSB = 0;
	localparam int SAMPLE_DATA_LSB = 16;

	localparam logic [APB_DW-1:0] CTRL_RESET = 32'h0000_03c0;
	localparam logic [APB_DW-1:0] SAMPLE_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		DECIM_NONE = 2'b00,
		DECIM_ONE = 2'b01,
		DECIM_TWO = 2'b10,
		DECIM_THREE = 2'b11
	} ffc_decim_e;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_ANSWER = 2'b01
	} ffc_apb_e;
endpackage

// >>> common/ffc_cell_if.sv
interface ffc_cell_if;
	logic [ffc_pkg::DCM_W-1:0] decim;
	logic [ffc_pkg::SEL_W-1:0] sel;
	logic clr_regs;
	logic clr_one;
	logic clr_all;
	logic [ffc_pkg::COEF_W-1:0] coef;
	logic [ffc_pkg::COEF_W-1:0] data;
	logic [ffc_pkg::RES_W-1:0] acc_read;

	modport ctl (
		output decim, sel, clr_regs, clr_one, clr_all, coef, data,
		input acc_read
	);
	modport cells (
		input decim, sel, clr_regs, clr_one, clr_all, coef, data,
		output acc_read
	);
endinterface

// >>> rtl/ffc_cells.sv
module ffc_cells (
	input wire logic clk,
	input wire logic rst,
	ffc_cell_if.cells bus
);
	import ffc_pkg::*;

	logic signed [COEF_W-1:0] x_reg;
	logic [COEF_W-1:0] c_reg [CELL_COUNT];
	logic [MAX_DECIM-1:0][COEF_W-1:0] d_reg [CELL_COUNT];
	logic [COEF_W-1:0] cout [CELL_COUNT+1];
	logic [RES_W-1:0] acc [CELL_COUNT];

	assign cout[0] = bus.coef;
	assign bus.acc_read = acc[bus.sel];

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			x_reg <= '0;
		else if (bus.clr_regs)
			x_reg <= '0;
		else
			x_reg <= bus.data;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	genvar i;
	generate
		for (i = 0; i < CELL_COUNT; i++) begin : g_cell
			logic signed [2*COEF_W-1:0] prod;
			logic [RES_W-1:0] prod_ext;

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					c_reg[i] <= '0;
					d_reg[i] <= '0;
				end else if (bus.clr_regs) begin
					c_reg[i] <= '0;
					d_reg[i] <= '0;
				end else begin
					c_reg[i] <= cout[i];
					d_reg[i] <= {d_reg[i][MAX_DECIM-2:0], c_reg[i]};
				end
			end

			// Each decimation register stretches the hop by one clock
			always_comb begin
				case (bus.decim)
					DECIM_NONE: cout[i+1] = c_reg[i];
					DECIM_ONE: cout[i+1] = d_reg[i][0];
					DECIM_TWO: cout[i+1] = d_reg[i][1];
					DECIM_THREE: cout[i+1] = d_reg[i][2];
					default: cout[i+1] = c_reg[i];
				endcase
			end

			assign prod = $signed(c_reg[i]) * x_reg;
			assign prod_ext = RES_W'(prod);

			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					acc[i] <= '0;
				else if (bus.clr_all)
					acc[i] <= '0;
				else if (bus.clr_one && bus.sel == SEL_W'(i))
					acc[i] <= '0;
				else
					acc[i] <= acc[i] + prod_ext;
			end

			AST_ACC_ONE: assert property (
				bus.clr_one && bus.sel == SEL_W'(i) |=> acc[i] == '0)
				else $error("selected accumulator not erased");
			AST_ACC_KEEP: assert property (
				bus.clr_one && !bus.clr_all && bus.sel != SEL_W'(i)
				|=> acc[i] == $past(acc[i]) + $past(prod_ext))
				else $error("unselected accumulator disturbed by erase");
			AST_ACC_ALL: assert property (
				bus.clr_all |=> acc[i] == '0)
				else $error("global clear missed an accumulator");
			if (i < CELL_COUNT - 1) begin : g_step
				AST_COEF_STEP: assert property (
					!bus.clr_regs ##1 (!bus.clr_regs && bus.decim == DECIM_ONE)
					|=> c_reg[i+1] == $past(c_reg[i], 2))
					else $error("coefficient hop not two clocks");
			end
		end
	endgenerate
endmodule // ffc_cells

// >>> rtl/ffc_fir_ctrl.sv
// Summary of operation
// - Coefficients hop cell to cell each clock, slower per decimation register.
// - Decimation select is registered, acting one clock later.
// - Result carries addressed accumulator or output-stage adder result, by shift-add.
// - High enable low drives result bits 16-25, otherwise they float.
// - Low enable low drives result bits 0-15, otherwise they float.
// - Cell select picks the accumulator read, added, or singly cleared.
// - Cell select is registered, acting one clock later.
// - Repeated selection keeps showing the value captured on its first clock.
// - Shift-add select is registered, acting one clock later.
// - Register clear low zeroes every internal register except accumulators.
// - Register clear is registered, acting one clock after the level.
// - Accumulator clear low zeroes only the selected cell's accumulator.
// - Both clears low zero all accumulators and all other registers.
// - Decimation codes 00..11 select zero to three decimation registers.
// - Both clears low take effect at the second edge after onset.
// - Output mux shows cell only if shift-add low now and before.
//
// Added by the designer: the address map and the APB register port.
module ffc_fir_ctrl (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ffc_pkg::APB_AW-1:0] PADDR,
	input wire logic [ffc_pkg::APB_DW-1:0] PWDATA,
	output logic [ffc_pkg::APB_DW-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [ffc_pkg::RES_W-1:0] RESULT_BUS,
	output logic RESULT_HIGH_OE,
	output logic RESULT_LOW_OE
);
	import ffc_pkg::*;

	ffc_cell_if cell_bus ();

	ffc_apb_e apb_state;
	logic access;
	logic wr_commit;
	logic [APB_DW-1:0] rd_word;

	logic [DCM_W-1:0] decimation_select;
	logic [SEL_W-1:0] cell_select;
	logic shift_add_select;
	logic register_clear_n;
	logic accumulator_clear_n;
	logic result_high_enable_n;
	logic result_low_enable_n;
	logic [COEF_W-1:0] coef_word;
	logic [COEF_W-1:0] data_word;

	logic [DCM_W-1:0] decim_q;
	logic [SEL_W-1:0] sel_q;
	logic shift_add_select_q;
	logic reg_clear_n_q;
	logic acc_clear_n_q;

	logic shift_add_select_prev;
	logic [SEL_W-1:0] sel_prev;
	logic sel_seen;
	logic new_sel;
	logic [RES_W-1:0] captured;
	logic [RES_W-1:0] out_buf;
	logic [RES_W-1:0] shift_term;
	logic [RES_W-1:0] next_out_buf;
	logic [RES_W-1:0] next_result;
	logic clr_regs;

	function automatic logic reg_hit(input logic [APB_AW-1:0] addr);
		reg_hit = (addr == CTRL_OFS) || (addr == SAMPLE_OFS) ||
			(addr == RESULT_OFS);
	endfunction

	assign access = PSEL && PENABLE;
	assign wr_commit = access && PREADY && PWRITE;

	// One wait state: ready rises one clock into the access phase
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			apb_state <= APB_IDLE;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= '0;
		end else begin
			case (apb_state)
				APB_IDLE: begin
					if (access) begin
						apb_state <= APB_ANSWER;
						PREADY <= 1'b1;
						PSLVERR <= !reg_hit(PADDR);
						PRDATA <= PWRITE ? '0 : rd_word;
					end
				end
				APB_ANSWER: begin
					apb_state <= APB_IDLE;
					PREADY <= 1'b0;
					PSLVERR <= 1'b0;
					PRDATA <= '0;
				end
				default: begin
					apb_state <= APB_IDLE;
					PREADY <= 1'b0;
					PSLVERR <= 1'b0;
					PRDATA <= '0;
				end
			endcase
		end
	end

	always_comb begin
		rd_word = '0;
		if (reg_hit(PADDR)) begin
			case (PADDR)
				CTRL_OFS: begin
					rd_word[CTRL_DCM_LSB +: DCM_W] = decimation_select;
					rd_word[CTRL_SEL_LSB +: SEL_W] = cell_select;
					rd_word[CTRL_SHIFT_ADD_SELECT_BIT] = shift_add_select;
					rd_word[CTRL_REGCLR_N_BIT] = register_clear_n;
					rd_word[CTRL_ACCCLR_N_BIT] = accumulator_clear_n;
					rd_word[CTRL_HIGH_EN_N_BIT] = result_high_enable_n;
					rd_word[CTRL_LOW_EN_N_BIT] = result_low_enable_n;
				end
				SAMPLE_OFS: begin
					rd_word[SAMPLE_COEF_LSB +: COEF_W] = coef_word;
					rd_word[SAMPLE_DATA_LSB +: COEF_W] = data_word;
				end
				RESULT_OFS: rd_word[RES_W-1:0] = RESULT_BUS;
				default: rd_word = '0;
			endcase
		end
	end

	// Control word: software plays the system controller's pins
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			decimation_select <= CTRL_RESET[CTRL_DCM_LSB +: DCM_W];
			cell_select <= CTRL_RESET[CTRL_SEL_LSB +: SEL_W];
			shift_add_select <= CTRL_RESET[CTRL_SHIFT_ADD_SELECT_BIT];
			register_clear_n <= CTRL_RESET[CTRL_REGCLR_N_BIT];
			accumulator_clear_n <= CTRL_RESET[CTRL_ACCCLR_N_BIT];
			result_high_enable_n <= CTRL_RESET[CTRL_HIGH_EN_N_BIT];
			result_low_enable_n <= CTRL_RESET[CTRL_LOW_EN_N_BIT];
			RESULT_HIGH_OE <= !CTRL_RESET[CTRL_HIGH_EN_N_BIT];
			RESULT_LOW_OE <= !CTRL_RESET[CTRL_LOW_EN_N_BIT];
		end else if (wr_commit && PADDR == CTRL_OFS) begin
			decimation_select <= PWDATA[CTRL_DCM_LSB +: DCM_W];
			cell_select <= PWDATA[CTRL_SEL_LSB +: SEL_W];
			shift_add_select <= PWDATA[CTRL_SHIFT_ADD_SELECT_BIT];
			register_clear_n <= PWDATA[CTRL_REGCLR_N_BIT];
			accumulator_clear_n <= PWDATA[CTRL_ACCCLR_N_BIT];
			result_high_enable_n <= PWDATA[CTRL_HIGH_EN_N_BIT];
			result_low_enable_n <= PWDATA[CTRL_LOW_EN_N_BIT];
			// Enables bypass the control pipeline so drivers switch at once
			RESULT_HIGH_OE <= !PWDATA[CTRL_HIGH_EN_N_BIT];
			RESULT_LOW_OE <= !PWDATA[CTRL_LOW_EN_N_BIT];
		end
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			coef_word <= SAMPLE_RESET[SAMPLE_COEF_LSB +: COEF_W];
			data_word <= SAMPLE_RESET[SAMPLE_DATA_LSB +: COEF_W];
		end else if (wr_commit && PADDR == SAMPLE_OFS) begin
			coef_word <= PWDATA[SAMPLE_COEF_LSB +: COEF_W];
			data_word <= PWDATA[SAMPLE_DATA_LSB +: COEF_W];
		end
	end

	// Input latches: every control except the output enables acts one clock after it is presented
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			decim_q <= DECIM_NONE;
			sel_q <= '0;
			shift_add_select_q <= 1'b0;
			reg_clear_n_q <= 1'b1;
			acc_clear_n_q <= 1'b1;
		end else begin
			decim_q <= decimation_select;
			sel_q <= cell_select;
			shift_add_select_q <= shift_add_select;
			reg_clear_n_q <= register_clear_n;
			acc_clear_n_q <= accumulator_clear_n;
		end
	end

	assign clr_regs = !reg_clear_n_q;
	assign cell_bus.decim = decim_q;
	assign cell_bus.sel = sel_q;
	assign cell_bus.clr_regs = clr_regs;
	assign cell_bus.clr_all = clr_regs && !acc_clear_n_q;
	assign cell_bus.clr_one = !clr_regs && !acc_clear_n_q;
	assign cell_bus.coef = coef_word;
	assign cell_bus.data = data_word;

	ffc_cells u_cells (
		.clk(CORE_CLK),
		.rst(RESET),
		.bus(cell_bus)
	);

	// Only the eighteen upper buffer bits feed back; the low eight are lost
	assign shift_term = shift_add_select_q ?
		{{BUF_DROP{out_buf[RES_W-1]}}, out_buf[RES_W-1:BUF_DROP]} : '0;
	assign next_out_buf = cell_bus.acc_read + shift_term;
	assign new_sel = !sel_seen || (sel_q != sel_prev);
	assign next_result = (!shift_add_select_q && !shift_add_select_prev) ? captured : out_buf;

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			out_buf <= '0;
			shift_add_select_prev <= 1'b0;
		end else if (clr_regs) begin
			out_buf <= '0;
			shift_add_select_prev <= 1'b0;
		end else begin
			out_buf <= next_out_buf;
			shift_add_select_prev <= shift_add_select_q;
		end
	end

	// Holding the first value lets slow memories read one address at leisure
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			captured <= '0;
			sel_prev <= '0;
			sel_seen <= 1'b0;
		end else if (clr_regs) begin
			captured <= '0;
			sel_prev <= '0;
			sel_seen <= 1'b0;
		end else begin
			if (new_sel)
				captured <= cell_bus.acc_read;
			sel_prev <= sel_q;
			sel_seen <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			RESULT_BUS <= '0;
		else if (clr_regs)
			RESULT_BUS <= '0;
		else
			RESULT_BUS <= next_result;
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	AST_DECIM_LATCH: assert property (
		##1 cell_bus.decim == $past(decimation_select))
		else $error("decimation select not delayed by one clock");
	AST_SEL_LATCH: assert property (
		##1 cell_bus.sel == $past(cell_select))
		else $error("cell select not delayed by one clock");
	AST_SHIFT_ADD_SELECT_ADD: assert property (
		!clr_regs && shift_add_select_q |=> out_buf == $past(cell_bus.acc_read) +
			{{BUF_DROP{$past(out_buf[RES_W-1])}},
			$past(out_buf[RES_W-1:BUF_DROP])})
		else $error("shift-and-add result wrong");
	AST_PLAIN_ADD: assert property (
		!clr_regs && !shift_add_select_q |=> out_buf == $past(cell_bus.acc_read))
		else $error("output stage did not load selected accumulator");
	AST_HIGH_OE: assert property (
		RESULT_HIGH_OE == !result_high_enable_n)
		else $error("high result drivers disagree with enable");
	AST_LOW_OE: assert property (
		RESULT_LOW_OE == !result_low_enable_n)
		else $error("low result drivers disagree with enable");
	AST_MUX_CELL: assert property (
		!clr_regs && !shift_add_select_q && !shift_add_select_prev |=> RESULT_BUS == $past(captured))
		else $error("result mux failed to show cell value");
	AST_MUX_BUF: assert property (
		!clr_regs && (shift_add_select_q || shift_add_select_prev) |=> RESULT_BUS == $past(out_buf))
		else $error("result mux failed to show output buffer");
	AST_HOLD: assert property (
		!clr_regs && sel_seen && sel_q == sel_prev |=> $stable(captured))
		else $error("held selection result changed");
	AST_REG_CLEAR: assert property (
		clr_regs |=> out_buf == '0 && captured == '0 && RESULT_BUS == '0)
		else $error("register clear left state behind");
	AST_CLEAR_DELAY: assert property (
		!register_clear_n && !accumulator_clear_n
		|=> cell_bus.clr_all ##1 RESULT_BUS == '0)
		else $error("global clear not at second edge");
	AST_APB_WAIT: assert property (
		access && !PREADY |=> PREADY ##1 !PREADY)
		else $error("APB answer not after one wait state");
	AST_APB_ERR: assert property (
		access && !PREADY && !reg_hit(PADDR) |=> PSLVERR && PRDATA == '0)
		else $error("unmapped access not refused");
	AST_CAPTURE: assert property (
		!clr_regs && new_sel |=> captured == $past(cell_bus.acc_read))
		else $error("new selection did not capture accumulator");
	AST_SHIFT_ADD_SELECT_LATCH: assert property (
		##1 shift_add_select_q == $past(shift_add_select))
		else $error("shift-add select not delayed by one clock");
	AST_CLEAR_LATCH: assert property (
		##1 clr_regs == !$past(register_clear_n))
		else $error("register clear not delayed by one clock");

	COV_SHIFT_ADD: cover property (shift_add_select_q [*3] ##1 !shift_add_select_q);
	COV_HOLD: cover property (sel_seen && sel_q == sel_prev [*3]);
	COV_ERASE_ONE: cover property (cell_bus.clr_one ##1 !cell_bus.clr_one);
	COV_DECIM_THREE: cover property (cell_bus.decim == DECIM_THREE [*2]);
	COV_SPLIT_READ: cover property (RESULT_LOW_OE && !RESULT_HIGH_OE
		##[1:20] RESULT_HIGH_OE && !RESULT_LOW_OE);
endmodule // ffc_fir_ctrl

// >>> test/ffc_bus_host.sv
module ffc_bus_host (
	input wire logic clk,
	input wire logic [ffc_pkg::RES_W-1:0] drv,
	input wire logic hi_oe,
	input wire logic lo_oe,
	output logic [ffc_pkg::RES_W-1:0] bus_q
);
	timeunit 1ns;
	timeprecision 1ns;
	import ffc_pkg::*;
	logic [RES_W-1:0] held = '0;
	// No pull resistor: a released half shows the inverse of the last drive,
	// so a stale value never passes for a fresh one
	assign bus_q[25:16] = hi_oe ? drv[25:16] : ~held[25:16];
	assign bus_q[15:0] = lo_oe ? drv[15:0] : ~held[15:0];
	always @(posedge clk) begin
		if (hi_oe) begin
			held[25:16] <= drv[25:16];
		end
		if (lo_oe) begin
			held[15:0] <= drv[15:0];
		end
	end
endmodule // ffc_bus_host

// >>> test/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ffc_pkg::*;
	logic CORE_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [APB_AW-1:0] PADDR = '0;
	logic [APB_DW-1:0] PWDATA = '0, PRDATA, rd, v2;
	logic PREADY, PSLVERR, RESULT_HIGH_OE, RESULT_LOW_OE, er;
	logic [RES_W-1:0] RESULT_BUS, bus_q;
	logic [1:0] dec = 2'b00;
	int errors = 0, tests_run = 0;

	ffc_fir_ctrl ffc_fir_ctrl_inst (.CORE_CLK(CORE_CLK), .RESET(RESET),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .RESULT_BUS(RESULT_BUS),
		.RESULT_HIGH_OE(RESULT_HIGH_OE), .RESULT_LOW_OE(RESULT_LOW_OE));
	ffc_bus_host ffc_bus_host_inst (.clk(CORE_CLK), .drv(RESULT_BUS),
		.hi_oe(RESULT_HIGH_OE), .lo_oe(RESULT_LOW_OE), .bus_q(bus_q));

	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	task tally_and_finish;
		$display("compares %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Entered right after a rising edge; an idle edge follows each transfer
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 20) begin
			errors++;
			tally_and_finish();
		end
		@(posedge CORE_CLK);
	endtask

	// f packs low-enable_n, high-enable_n, acc clear_n, reg clear_n, shift-add
	function automatic logic [31:0] cv(input logic [2:0] s,
		input logic [4:0] f);
		return {22'h0, f, s, dec};
	endfunction

	task wctl(input logic [31:0] v);
		apb(1'b1, CTRL_OFS, v);
		repeat (4) @(posedge CORE_CLK);
	endtask

	task rsel(input logic [2:0] s);
		wctl(cv(s, 5'b11110));
		apb(1'b0, RESULT_OFS, 32'h0);
	endtask

	task feed(input int on);
		apb(1'b1, SAMPLE_OFS, 32'h00ff_00ff);
		repeat (on) @(posedge CORE_CLK);
		apb(1'b1, SAMPLE_OFS, 32'h0);
		repeat (20) @(posedge CORE_CLK);
	endtask

	task clr_all;
		wctl(cv(3'h0, 5'b11000));
		wctl(cv(3'h0, 5'b11110));
	endtask

	task t_reset;
		chk({6'h0, RESULT_BUS}, 32'h0);
		chk({30'h0, RESULT_HIGH_OE, RESULT_LOW_OE}, 32'h0);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rd, CTRL_RESET);
		chk({31'h0, er}, 32'h0);
		apb(1'b0, SAMPLE_OFS, 32'h0);
		chk(rd, SAMPLE_RESET);
		apb(1'b1, 12'h00c, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, RESULT_OFS, 32'h0000_1234);
		apb(1'b0, RESULT_OFS, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
	endtask

	task t_clear;
		feed(30);
		rsel(3'h4);
		chk({31'h0, rd != 32'h0}, 32'h1);
		clr_all();
		for (int s = 0; s < 8; s++) begin
			rsel(s[2:0]);
			chk(rd, 32'h0);
		end
		$display("clear-all test done");
	endtask

	task t_hold;
		apb(1'b1, SAMPLE_OFS, 32'h00ff_00ff);
		rsel(3'h5);
		v2 = rd;
		repeat (10) @(posedge CORE_CLK);
		apb(1'b0, RESULT_OFS, 32'h0);
		chk(rd, v2);
		apb(1'b1, SAMPLE_OFS, 32'h0);
		repeat (20) @(posedge CORE_CLK);
		rsel(3'h2);
		v2 = rd;
		chk({31'h0, v2 != 32'h0}, 32'h1);
		wctl(cv(3'h3, 5'b11010));
		// A selection shows its first-clock value, so cell 3 is left and
		// entered again before its cleared accumulator can be seen
		rsel(3'h2);
		chk(rd, v2);
		rsel(3'h3);
		chk(rd, 32'h0);
		rsel(3'h2);
		chk(rd, v2);
		apb(1'b1, CTRL_OFS, cv(3'h2, 5'b11100));
		chk({6'h0, RESULT_BUS}, v2);
		repeat (4) @(posedge CORE_CLK);
		chk({6'h0, RESULT_BUS}, 32'h0);
		rsel(3'h5);
		rsel(3'h2);
		chk(rd, v2);
		$display("hold and single clear test done");
	endtask

	task t_oe;
		logic [9:0] hp;
		wctl(cv(3'h2, 5'b10110));
		chk({30'h0, RESULT_HIGH_OE, RESULT_LOW_OE}, 32'h2);
		chk({31'h0, bus_q[15:0] === RESULT_BUS[15:0]}, 32'h0);
		hp = bus_q[25:16];
		wctl(cv(3'h2, 5'b01110));
		chk({30'h0, RESULT_HIGH_OE, RESULT_LOW_OE}, 32'h1);
		chk({31'h0, bus_q[25:16] === RESULT_BUS[25:16]}, 32'h0);
		chk({6'h0, hp, bus_q[15:0]}, v2);
		wctl(cv(3'h2, 5'b00110));
		chk({6'h0, bus_q}, v2);
		apb(1'b0, RESULT_OFS, 32'h0);
		chk(rd, v2);
		$display("enable test done");
	endtask

	task t_shift_add_select;
		apb(1'b1, CTRL_OFS, cv(3'h2, 5'b11111));
		chk({6'h0, RESULT_BUS}, v2);
		repeat (4) @(posedge CORE_CLK);
		apb(1'b0, RESULT_OFS, 32'h0);
		chk({31'h0, rd != v2}, 32'h1);
		wctl(cv(3'h2, 5'b11110));
		apb(1'b0, RESULT_OFS, 32'h0);
		chk(rd, v2);
		$display("shift-add test done");
	endtask

	// Short feed: the coefficient reaches cell 7 in time only when it hops
	// every clock or every two clocks, so deeper decimation leaves that cell empty
	task t_decim;
		for (int d = 0; d < 4; d++) begin
			dec = d[1:0];
			clr_all();
			feed(12);
			// Clearing left cell 0 selected, so cell 7 is read first
			rsel(3'h7);
			if (d == 0)
				chk({31'h0, rd != 32'h0}, 32'h1);
			// Two-clock hops leave cell 7 with just two products
			if (d == 1)
				chk(rd, 32'h0001_fc02);
			if (d >= 2)
				chk(rd, 32'h0);
			rsel(3'h0);
			chk({31'h0, rd != 32'h0}, 32'h1);
		end
		$display("decimation test done");
	endtask

	task t_reset_again;
		wctl(cv(3'h6, 5'b00110));
		RESET <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RESET <= 1'b0;
		@(posedge CORE_CLK);
		chk({30'h0, RESULT_HIGH_OE, RESULT_LOW_OE}, 32'h0);
		chk({6'h0, RESULT_BUS}, 32'h0);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rd, CTRL_RESET);
		rsel(3'h0);
		chk(rd, 32'h0);
		$display("mid-run reset test done");
	endtask

	initial begin
		repeat (10) @(posedge CORE_CLK);
		RESET <= 1'b0;
		@(posedge CORE_CLK);
		t_reset();
		t_clear();
		t_hold();
		t_oe();
		t_shift_add_select();
		t_decim();
		t_reset_again();
		tally_and_finish();
	end
endmodule // tb_top
